// *** cim_map.svh ***
// Constants of the custom-instruction port: widths, codes, defaults.
// Assumes inclusion by cim_pkg, the port modules and the bench only.
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH

`define CIM_WORD_W       32
`define CIM_EXT_MAX      8
`define CIM_ADDR_W       5
`define CIM_IDLE_W       16
`define CIM_ERR_W        2
`define CIM_TMO_W        16
`define CIM_CNT_W        8

`define CIM_OPER_DEF     2
`define CIM_FIXED_DEF    2
`define CIM_EXT_W_DEF    1
`define CIM_COMB_LAT     1
`define CIM_DEPTH_DEF    8

`define CIM_ERR_NONE     2'h0
`define CIM_ERR_NO_START 2'h1
`define CIM_ERR_BAD_DATA 2'h2
`define CIM_ERR_NO_ISSUE 2'h3

`define CIM_OP_ADD       2'h0
`define CIM_OP_XOR       2'h1
`define CIM_OP_PASS      2'h2

`define CIM_SEL_IDLE     1'b1
`define CIM_GATE_RST     1'b1

`endif

// *** cim_pkg.sv ***
// Types shared by both ends of the custom-instruction port.
// Assumes cim_map.svh is on the include path.
`include "cim_map.svh"

package cim_pkg;

  typedef logic [`CIM_WORD_W-1:0]  cim_word_type_t;
  typedef logic [`CIM_EXT_MAX-1:0] cim_ext_opcode_type_t;
  typedef logic [`CIM_ADDR_W-1:0]  cim_regfile_index_type_t;

  typedef struct packed {
    cim_word_type_t          dataa;
    cim_word_type_t          datab;
    cim_ext_opcode_type_t    n;
    cim_regfile_index_type_t a;
    cim_regfile_index_type_t b;
    cim_regfile_index_type_t c;
    logic                    readra;
    logic                    readrb;
    logic                    writerc;
    logic [`CIM_IDLE_W-1:0]  idle;
    logic [`CIM_ERR_W-1:0]   err_inj;
  } cim_instr_t;

  typedef enum logic [1:0] {
    CIM_S_IDLE = 2'b00,
    CIM_S_WAIT = 2'b01,
    CIM_S_BUSY = 2'b10
  } cim_mstate_t;

endpackage

// *** cim_if.sv ***
// Pin bundle between the instruction master and the slave logic.
// Assumes both ends run on the same sys_clk; absent pins are tied.
`timescale 1ns/1ps

interface cim_if;
  import cim_pkg::*;

  logic                    clk_en;
  logic                    start;
  logic                    done;
  cim_word_type_t          dataa;
  cim_word_type_t          datab;
  cim_ext_opcode_type_t    n;
  cim_regfile_index_type_t a;
  cim_regfile_index_type_t b;
  cim_regfile_index_type_t c;
  logic                    readra;
  logic                    readrb;
  logic                    writerc;
  cim_word_type_t          result;

  modport master (
    output clk_en, start, dataa, datab, n, a, b, c, readra, readrb, writerc,
    input  done, result
  );

  modport slave (
    input  clk_en, start, dataa, datab, n, a, b, c, readra, readrb, writerc,
    output done, result
  );
endinterface

// *** cim_fifo.sv ***
// Ordered queue with occupancy count and registered full/valid flags.
// Assumes one clock; pop is honoured only while out_valid is high.
`timescale 1ns/1ps

module cim_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int CW    = 8
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // Fill side
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  // Drain side
  input  wire logic          out_pop,
  output logic [W-1:0]       out_data,
  output logic               out_valid,
  output logic [CW-1:0]      count
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || DEPTH >= (1 << CW))
    $error("cim_fifo: DEPTH out of range");

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  assign push       = in_valid & in_ready;
  assign pop        = out_pop & out_valid;
  assign out_data   = mem[rd_ptr_reg];
  assign count_next = count + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count      <= '0;
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count     <= count_next;
      in_ready  <= (count_next != CW'(DEPTH));
      out_valid <= (count_next != '0);
    end
  end
endmodule // cim_fifo

// *** cim_master.sv ***
// Instruction master: queues instructions, drives them, collects results.
// Assumes the slave shares sys_clk; done and result need no synchroniser.
`timescale 1ns/1ps
`include "cim_map.svh"

module cim_master
  import cim_pkg::*;
#(
  parameter int N_OPER    = `CIM_OPER_DEF,
  parameter int FIXED_LEN = `CIM_FIXED_DEF,
  parameter bit USE_RES   = 1'b1,
  parameter bit USE_MULTI = 1'b0,
  parameter bit USE_START = 1'b1,
  parameter bit USE_DONE  = 1'b1,
  parameter bit USE_EXT   = 1'b0,
  parameter int EXT_W     = `CIM_EXT_W_DEF,
  parameter bit USE_RA    = 1'b0,
  parameter bit USE_RB    = 1'b0,
  parameter bit USE_RC    = 1'b0,
  parameter int IQ_DEPTH  = `CIM_DEPTH_DEF,
  parameter int RQ_DEPTH  = `CIM_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Port to slave logic
  cim_if.master                      bus,
  // Instruction queue
  input  wire logic                  iq_push,
  input  wire cim_instr_t            iq_data,
  output logic                       iq_ready,
  output logic [`CIM_CNT_W-1:0]      iq_count,
  // Result queue
  input  wire logic                  rq_pop,
  output logic [`CIM_CNT_W-1:0]      rq_count,
  output cim_word_type_t             res_value,
  output logic [`CIM_TMO_W-1:0]      res_delay,
  output logic                       res_valid,
  // Control
  input  wire logic                  gate_wr,
  input  wire logic                  gate_val,
  input  wire logic [`CIM_TMO_W-1:0] ce_tmo,
  input  wire logic [`CIM_TMO_W-1:0] instr_tmo,
  input  wire logic [`CIM_TMO_W-1:0] res_tmo,
  input  wire logic [`CIM_CNT_W-1:0] iq_max,
  input  wire logic [`CIM_CNT_W-1:0] iq_min,
  input  wire logic [`CIM_CNT_W-1:0] rq_max,
  input  wire logic [`CIM_CNT_W-1:0] rq_min,
  // Events
  output logic                       ev_instr_start,
  output logic                       ev_all_done,
  output logic                       ev_result,
  output logic                       ev_unexpected,
  output logic                       ev_fatal,
  output logic [1:0]                 ev_q_max,
  output logic [1:0]                 ev_q_min
);
  localparam int TW = `CIM_TMO_W;
  localparam int RW = `CIM_WORD_W + TW;
  localparam logic [TW-1:0] TARGET =
    USE_MULTI ? TW'(FIXED_LEN - 1) : TW'(`CIM_COMB_LAT);
  localparam cim_ext_opcode_type_t EXT_MASK = `CIM_EXT_MAX'((1 << EXT_W) - 1);
  localparam bit HAS_START = USE_MULTI & USE_START;
  localparam bit HAS_DONE  = USE_MULTI & USE_DONE;

  if (N_OPER < 0 || N_OPER > 2 || FIXED_LEN < 2 || EXT_W < 1 || EXT_W > `CIM_EXT_MAX)
    $error("cim_master: unsupported parameter value");

  cim_mstate_t     state_reg;
  cim_instr_t      cur_reg;
  cim_instr_t      iq_head;
  logic [`CIM_IDLE_W-1:0] cnt_reg;
  logic [TW-1:0]   lat_reg;
  logic [TW-1:0]   ce_cnt_reg;
  logic            iq_valid;
  logic            iq_pop;
  logic            rq_ready;
  logic            rq_valid;
  logic [RW-1:0]   rq_head;
  logic            en;
  logic            sample_now;
  logic            sample_ok;
  logic            ce_exp;
  logic            ins_exp;
  logic            res_exp;
  logic            abort;
  logic            issue;
  logic            inj_drop;
  logic            overflow;
  logic            finish;
  cim_word_type_t  res_in;

  cim_fifo #(.W($bits(cim_instr_t)), .DEPTH(IQ_DEPTH), .CW(`CIM_CNT_W)) u_iq (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (iq_push),
    .in_data   (iq_data),
    .in_ready  (iq_ready),
    .out_pop   (iq_pop),
    .out_data  (iq_head),
    .out_valid (iq_valid),
    .count     (iq_count)
  );

  cim_fifo #(.W(RW), .DEPTH(RQ_DEPTH), .CW(`CIM_CNT_W)) u_rq (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (sample_ok),
    .in_data   ({res_in, lat_reg + 1'b1}),
    .in_ready  (rq_ready),
    .out_pop   (rq_pop),
    .out_data  (rq_head),
    .out_valid (rq_valid),
    .count     (rq_count)
  );

  assign en         = bus.clk_en;
  assign res_in     = USE_RES ? bus.result : '0;
  assign iq_pop     = (state_reg == CIM_S_IDLE) & iq_valid;
  assign sample_now = (state_reg == CIM_S_BUSY) & en &
                      (HAS_DONE ? bus.done : (lat_reg == TARGET));
  assign ce_exp     = (ce_tmo != '0) & (ce_cnt_reg >= ce_tmo);
  assign ins_exp    = (state_reg == CIM_S_WAIT) & (instr_tmo != '0) &
                      (lat_reg >= instr_tmo);
  assign res_exp    = (state_reg == CIM_S_BUSY) & (res_tmo != '0) &
                      (lat_reg >= res_tmo) & !sample_now;
  assign abort      = (state_reg != CIM_S_IDLE) & (ce_exp | ins_exp | res_exp);
  assign issue      = (state_reg == CIM_S_WAIT) & en & (cnt_reg == '0) & !abort;
  assign inj_drop   = issue & (cur_reg.err_inj == `CIM_ERR_NO_ISSUE);
  assign overflow   = sample_now & !abort & !rq_ready;
  assign sample_ok  = sample_now & !abort & rq_ready;
  assign finish     = sample_ok | abort | inj_drop | overflow;

  // Clock gate register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      bus.clk_en <= `CIM_GATE_RST;
    else if (gate_wr)
      bus.clk_en <= gate_val;
  end

  // Sequencer
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= CIM_S_IDLE;
      cur_reg   <= '0;
      cnt_reg   <= '0;
      lat_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        CIM_S_IDLE:
        begin
          if (iq_valid)
          begin
            cur_reg   <= iq_head;
            cnt_reg   <= iq_head.idle;
            lat_reg   <= '0;
            state_reg <= CIM_S_WAIT;
          end
        end
        CIM_S_WAIT:
        begin
          if (abort || inj_drop)
            state_reg <= CIM_S_IDLE;
          else if (issue)
          begin
            lat_reg   <= '0;
            state_reg <= CIM_S_BUSY;
          end
          else
          begin
            lat_reg <= lat_reg + 1'b1;
            if (en)
              cnt_reg <= cnt_reg - 1'b1;
          end
        end
        CIM_S_BUSY:
        begin
          if (abort || sample_now)
            state_reg <= CIM_S_IDLE;
          else if (en)
            lat_reg <= lat_reg + 1'b1;
        end
        default: state_reg <= CIM_S_IDLE;
      endcase
    end
  end

  // Clock-gate stall counter
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ce_cnt_reg <= '0;
    else if (en || abort || (state_reg == CIM_S_IDLE && !iq_valid))
      ce_cnt_reg <= '0;
    else
      ce_cnt_reg <= ce_cnt_reg + 1'b1;
  end

  // Instruction pins
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.start   <= 1'b0;
      bus.dataa   <= '0;
      bus.datab   <= '0;
      bus.n       <= '0;
      bus.a       <= '0;
      bus.b       <= '0;
      bus.c       <= '0;
      bus.readra  <= `CIM_SEL_IDLE;
      bus.readrb  <= `CIM_SEL_IDLE;
      bus.writerc <= `CIM_SEL_IDLE;
    end
    else if (issue && !inj_drop)
    begin
      bus.start   <= HAS_START & (cur_reg.err_inj != `CIM_ERR_NO_START);
      bus.dataa   <= (N_OPER >= 1) ?
                     ((cur_reg.err_inj == `CIM_ERR_BAD_DATA) ? ~cur_reg.dataa : cur_reg.dataa)
                     : '0;
      bus.datab   <= (N_OPER == 2) ? cur_reg.datab : '0;
      bus.n       <= USE_EXT ? (cur_reg.n & EXT_MASK) : '0;
      bus.a       <= USE_RA ? cur_reg.a : '0;
      bus.b       <= USE_RB ? cur_reg.b : '0;
      bus.c       <= USE_RC ? cur_reg.c : '0;
      bus.readra  <= USE_RA ? cur_reg.readra : `CIM_SEL_IDLE;
      bus.readrb  <= USE_RB ? cur_reg.readrb : `CIM_SEL_IDLE;
      bus.writerc <= USE_RC ? cur_reg.writerc : `CIM_SEL_IDLE;
    end
    else if (finish)
    begin
      bus.start   <= 1'b0;
      bus.dataa   <= '0;
      bus.datab   <= '0;
      bus.n       <= '0;
      bus.a       <= '0;
      bus.b       <= '0;
      bus.c       <= '0;
      bus.readra  <= `CIM_SEL_IDLE;
      bus.readrb  <= `CIM_SEL_IDLE;
      bus.writerc <= `CIM_SEL_IDLE;
    end
    else if (state_reg == CIM_S_BUSY && en)
      bus.start <= 1'b0;
  end

  // Result read-out
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      res_value <= '0;
      res_delay <= '0;
      res_valid <= 1'b0;
    end
    else
    begin
      res_valid <= rq_pop & rq_valid;
      if (rq_pop && rq_valid)
        {res_value, res_delay} <= rq_head;
    end
  end

  // Event pulses
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ev_instr_start <= 1'b0;
      ev_all_done    <= 1'b0;
      ev_result      <= 1'b0;
      ev_unexpected  <= 1'b0;
      ev_fatal       <= 1'b0;
    end
    else
    begin
      ev_instr_start <= issue & !inj_drop;
      ev_all_done    <= finish & !iq_valid;
      ev_result      <= sample_ok;
      ev_unexpected  <= HAS_DONE & bus.done & (state_reg != CIM_S_BUSY);
      ev_fatal       <= abort | inj_drop | overflow;
    end
  end

  // Queue thresholds: index 0 instructions, 1 results
  logic [`CIM_CNT_W-1:0] q_cnt [2];
  logic [`CIM_CNT_W-1:0] q_max [2];
  logic [`CIM_CNT_W-1:0] q_min [2];
  assign q_cnt[0] = iq_count;
  assign q_cnt[1] = rq_count;
  assign q_max[0] = iq_max;
  assign q_max[1] = rq_max;
  assign q_min[0] = iq_min;
  assign q_min[1] = rq_min;

  for (genvar g = 0; g < 2; g++)
  begin : g_thr
    logic hi_reg;
    logic lo_reg;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        hi_reg      <= 1'b0;
        lo_reg      <= 1'b0;
        ev_q_max[g] <= 1'b0;
        ev_q_min[g] <= 1'b0;
      end
      else
      begin
        hi_reg      <= (q_cnt[g] > q_max[g]);
        lo_reg      <= (q_cnt[g] < q_min[g]);
        ev_q_max[g] <= (q_cnt[g] > q_max[g]) & !hi_reg;
        ev_q_min[g] <= (q_cnt[g] < q_min[g]) & !lo_reg;
      end
    end
  end
endmodule // cim_master

// *** cim_slave.sv ***
// Slave logic end: computes a result per qualified instruction.
// Assumes the master shares sys_clk; options must match the master's.
`timescale 1ns/1ps
`include "cim_map.svh"

module cim_slave
  import cim_pkg::*;
#(
  parameter bit USE_RES   = 1'b1,
  parameter bit USE_MULTI = 1'b0,
  parameter bit USE_START = 1'b1,
  parameter bit USE_DONE  = 1'b1
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Port from master
  cim_if.slave                       bus,
  // Behaviour select
  input  wire logic [1:0]            op_sel,
  input  wire logic [`CIM_TMO_W-1:0] done_delay,
  // Observation
  output logic                       seen_valid,
  output cim_word_type_t             seen_dataa,
  output cim_word_type_t             seen_datab,
  output cim_ext_opcode_type_t       seen_n
);
  localparam bit HAS_START = USE_MULTI & USE_START;
  localparam bit HAS_DONE  = USE_MULTI & USE_DONE;

  logic                  qual;
  logic                  pend_reg;
  logic [`CIM_TMO_W-1:0] wait_reg;
  cim_word_type_t        calc;
  cim_word_type_t        hold_reg;

  // Start qualifies one instruction; otherwise every enabled cycle does
  assign qual = bus.clk_en & (HAS_START ? bus.start : 1'b1);

  always_comb
  begin
    case (op_sel)
      `CIM_OP_ADD:  calc = bus.dataa + bus.datab + `CIM_WORD_W'(bus.n);
      `CIM_OP_XOR:  calc = bus.dataa ^ bus.datab;
      `CIM_OP_PASS: calc = bus.dataa;
      default:      calc = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.result <= '0;
      bus.done   <= 1'b0;
      pend_reg   <= 1'b0;
      wait_reg   <= '0;
      hold_reg   <= '0;
    end
    else if (HAS_DONE)
    begin
      bus.done <= 1'b0;
      if (qual && !pend_reg)
      begin
        pend_reg <= 1'b1;
        wait_reg <= done_delay;
        hold_reg <= calc;
      end
      else if (pend_reg && bus.clk_en)
      begin
        if (wait_reg == '0)
        begin
          pend_reg   <= 1'b0;
          bus.done   <= 1'b1;
          bus.result <= USE_RES ? hold_reg : '0;
        end
        else
          wait_reg <= wait_reg - 1'b1;
      end
    end
    else if (qual)
      bus.result <= USE_RES ? calc : '0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_valid <= 1'b0;
      seen_dataa <= '0;
      seen_datab <= '0;
      seen_n     <= '0;
    end
    else
    begin
      seen_valid <= qual;
      if (qual)
      begin
        seen_dataa <= bus.dataa;
        seen_datab <= bus.datab;
        seen_n     <= bus.n;
      end
    end
  end
endmodule // cim_slave

// *** cim_master_properties.sv ***
// Concurrent checks on the pins between instruction master and slave.
// Assumes multi-cycle mode with start and done, optional ports left off.
`timescale 1ns/1ps

module cim_master_properties
  import cim_pkg::*;
(
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  // Port pins
  input wire logic                    clk_en,
  input wire logic                    start,
  input wire logic                    done,
  input wire cim_word_type_t          dataa,
  input wire cim_word_type_t          datab,
  input wire cim_ext_opcode_type_t    n,
  input wire cim_regfile_index_type_t a,
  input wire cim_regfile_index_type_t b,
  input wire cim_regfile_index_type_t c,
  input wire logic                    readra,
  input wire logic                    readrb,
  input wire logic                    writerc,
  input wire cim_word_type_t          result
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_start_one_cycle: assert property (start && clk_en |=> !start)
    else $error("start held too long");
  a_selects_high: assert property (readra && readrb && writerc)
    else $error("select pin low");
  a_index_absent: assert property (a == '0 && b == '0 && c == '0)
    else $error("index pin driven");
  a_ext_absent: assert property (n == '0)
    else $error("extended opcode driven");
  a_done_bound: assert property ($rose(start) |-> ##[2:200] done)
    else $error("done missing after start");
  a_pins_hold: assert property (start && clk_en |=> $stable(dataa) && $stable(datab))
    else $error("operands moved in flight");
  a_idle_after: assert property (done |=> dataa == '0 && datab == '0)
    else $error("operands not idle");
  a_result_held: assert property ($changed(result) |-> done)
    else $error("result moved without done");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than a cycle");
  a_start_no_done: assert property (start |-> !done)
    else $error("done with start");
endmodule // cim_master_properties

// *** custom_instruction_master_driver_tb.sv ***
// Self-checking bench: master and slave joined over the port bundle.
// Assumes multi-cycle mode with start and done, slave in add mode.
`timescale 1ns/1ps
`include "cim_map.svh"

module custom_instruction_master_driver_tb
  import cim_pkg::*;
;
  logic           sys_clk, rstn, iq_push, iq_ready, rq_pop, res_valid;
  logic           gate_wr, gate_val, ev_st, ev_ad, ev_rs, ev_ux, ev_ft, tally_clr;
  logic [1:0]     ev_qx, ev_qn, op_sel;
  logic [7:0]     iq_count, rq_count, iq_max, iq_min, rq_max, rq_min;
  logic [7:0]     n_st, n_ad, n_rs, n_ux, n_ft, n_qx, n_qn;
  logic [15:0]    res_delay, ce_tmo, instr_tmo, res_tmo, done_delay;
  cim_instr_t     iq_data;
  cim_word_type_t res_value, seen_a, seen_b, va, vb;
  cim_word_type_t exp_q[$];
  int             bad_count, check_count;

  cim_if bus_if ();
  cim_master #(.USE_MULTI(1'b1)) cim_master_i (
    .sys_clk(sys_clk), .rstn(rstn), .bus(bus_if), .iq_push(iq_push), .iq_data(iq_data),
    .iq_ready(iq_ready), .iq_count(iq_count), .rq_pop(rq_pop), .rq_count(rq_count),
    .res_value(res_value), .res_delay(res_delay), .res_valid(res_valid),
    .gate_wr(gate_wr), .gate_val(gate_val), .ce_tmo(ce_tmo), .instr_tmo(instr_tmo),
    .res_tmo(res_tmo), .iq_max(iq_max), .iq_min(iq_min), .rq_max(rq_max), .rq_min(rq_min),
    .ev_instr_start(ev_st), .ev_all_done(ev_ad), .ev_result(ev_rs), .ev_unexpected(ev_ux),
    .ev_fatal(ev_ft), .ev_q_max(ev_qx), .ev_q_min(ev_qn));
  cim_slave #(.USE_MULTI(1'b1)) cim_slave_i (
    .sys_clk(sys_clk), .rstn(rstn), .bus(bus_if), .op_sel(op_sel), .done_delay(done_delay),
    .seen_valid(), .seen_dataa(seen_a), .seen_datab(seen_b), .seen_n());
  cim_master_properties cim_master_properties_i (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(bus_if.clk_en), .start(bus_if.start),
    .done(bus_if.done), .dataa(bus_if.dataa), .datab(bus_if.datab), .n(bus_if.n),
    .a(bus_if.a), .b(bus_if.b), .c(bus_if.c), .readra(bus_if.readra),
    .readrb(bus_if.readrb), .writerc(bus_if.writerc), .result(bus_if.result));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Event pulse tallies, zeroed while tally_clr is high
  always @(posedge sys_clk)
  begin
    if (tally_clr)
      {n_st, n_ad, n_rs, n_ux, n_ft, n_qx, n_qn} <= '0;
    else
    begin
      n_st <= n_st + ev_st;
      n_ad <= n_ad + ev_ad;
      n_rs <= n_rs + ev_rs;
      n_ux <= n_ux + ev_ux;
      n_ft <= n_ft + ev_ft;
      n_qx <= n_qx + ev_qx[0] + ev_qx[1];
      n_qn <= n_qn + ev_qn[1];
    end
  end

  function automatic cim_word_type_t calc(cim_word_type_t x, cim_word_type_t y, logic [1:0] e);
    return (e == `CIM_ERR_BAD_DATA ? ~x : x) + y;
  endfunction

  task automatic chk_w(cim_word_type_t got, cim_word_type_t exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_c(logic [7:0] got, logic [7:0] exp);
    chk_w({24'h000000, got}, {24'h000000, exp});
  endtask

  task automatic clr();
    @(negedge sys_clk);
    tally_clr = 1'b1;
    @(negedge sys_clk);
    tally_clr = 1'b0;
  endtask

  // Each cycle also ends any push left standing
  task automatic wait_n(int k);
    repeat (k)
    begin
      @(negedge sys_clk);
      iq_push = 1'b0;
    end
  endtask

  task automatic push(cim_word_type_t x, cim_word_type_t y, logic [15:0] i, logic [1:0] e);
    @(negedge sys_clk);
    iq_push = 1'b1;
    iq_data = '{dataa: x, datab: y, readra: 1'b1, readrb: 1'b1, writerc: 1'b1,
                idle: i, err_inj: e, default: '0};
  endtask

  task automatic wait_rq(logic [7:0] k);
    for (int i = 0; i < 400 && rq_count !== k; i++) wait_n(1);
    wait_n(1);
    chk_c(rq_count, k);
  endtask

  task automatic pop(cim_word_type_t e, logic [15:0] d);
    @(negedge sys_clk);
    rq_pop = 1'b1;
    wait_n(1);
    rq_pop = 1'b0;
    chk_c({7'h00, res_valid}, 8'h01);
    chk_w(res_value, e);
    chk_w({16'h0000, res_delay}, {16'h0000, d});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #50us;
    bad_count++;
    summarize();
  end

  initial
  begin
    rstn = 1'b0;
    iq_push = 1'b0;
    iq_data = '0;
    rq_pop = 1'b0;
    gate_wr = 1'b0;
    gate_val = 1'b1;
    tally_clr = 1'b1;
    ce_tmo = '0;
    instr_tmo = '0;
    res_tmo = '0;
    iq_max = 8'h02;
    iq_min = '0;
    rq_max = 8'h03;
    rq_min = '0;
    op_sel = `CIM_OP_ADD;
    bad_count = 0;
    check_count = 0;
    va = $urandom(32'hFCED14A9);
    done_delay = 16'($urandom_range(5));
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    chk_c(iq_count, 8'h00);
    chk_c({7'h00, iq_ready}, 8'h01);
    chk_c({7'h00, bus_if.clk_en}, {7'h00, `CIM_GATE_RST});
    chk_c({5'h00, bus_if.readra, bus_if.readrb, bus_if.writerc}, 8'h07);
    $display("test reset done");

    clr();
    for (int i = 0; i < 5; i++)
    begin
      va = $urandom;
      vb = $urandom;
      exp_q.push_back(calc(va, vb, `CIM_ERR_NONE));
      push(va, vb, 16'($urandom_range(3)), `CIM_ERR_NONE);
    end
    wait_rq(8'h05);
    chk_c(n_st, 8'h05);
    chk_c(n_rs, 8'h05);
    chk_c({7'h00, n_ad != 8'h00}, 8'h01);
    chk_c(n_qx, 8'h02);
    chk_w(seen_a, va);
    chk_w(seen_b, vb);
    rq_min = 8'h02;
    while (exp_q.size() != 0) pop(exp_q.pop_front(), done_delay + 16'h0003);
    wait_n(2);
    chk_c(n_qn, 8'h01);
    rq_min = '0;
    $display("test burst done");

    clr();
    res_tmo = 16'h0005;
    done_delay = 16'h0014;
    push($urandom, $urandom, '0, `CIM_ERR_NONE);
    wait_n(60);
    chk_c(n_ft, 8'h01);
    chk_c(n_ux, 8'h01);
    chk_c(rq_count, 8'h00);
    chk_c(n_ad, 8'h01);
    done_delay = 16'($urandom_range(4));
    $display("test late result done");

    res_tmo = 16'h0008;
    for (logic [1:0] e = 2'h1; e != 2'h0; e++)
    begin
      clr();
      va = $urandom;
      vb = $urandom;
      push(va, vb, '0, e);
      wait_n(40);
      chk_c(n_ft, {7'h00, e != `CIM_ERR_BAD_DATA});
      chk_c(rq_count, {7'h00, e == `CIM_ERR_BAD_DATA});
      if (e == `CIM_ERR_BAD_DATA)
        pop(calc(va, vb, e), done_delay + 16'h0003);
    end
    res_tmo = '0;
    $display("test error inject done");

    clr();
    instr_tmo = 16'h000A;
    push($urandom, $urandom, 16'h0032, `CIM_ERR_NONE);
    wait_n(40);
    chk_c(n_ft, 8'h01);
    chk_c(n_st, 8'h00);
    chk_c(iq_count, 8'h00);
    instr_tmo = '0;
    push(va, vb, 16'h0010, `CIM_ERR_NONE);
    wait_n(12);
    chk_c(n_st, 8'h00);
    wait_rq(8'h01);
    chk_c(n_st, 8'h01);
    pop(calc(va, vb, `CIM_ERR_NONE), done_delay + 16'h0003);
    $display("test idle done");

    clr();
    gate_val = 1'b0;
    gate_wr = 1'b1;
    chk_c({7'h00, bus_if.clk_en}, 8'h01);
    wait_n(1);
    gate_wr = 1'b0;
    chk_c({7'h00, bus_if.clk_en}, 8'h00);
    ce_tmo = 16'h0006;
    push($urandom, $urandom, '0, `CIM_ERR_NONE);
    wait_n(20);
    chk_c(n_ft, 8'h01);
    chk_c(rq_count, 8'h00);
    ce_tmo = '0;
    gate_val = 1'b1;
    gate_wr = 1'b1;
    wait_n(1);
    gate_wr = 1'b0;
    chk_c({7'h00, bus_if.clk_en}, 8'h01);
    $display("test clock gate done");
    summarize();
  end
endmodule // custom_instruction_master_driver_tb
